// ### pwm_deadband_autoshutdown.sv
// PWM output stage with dead-band insertion, auto-shutdown and an AXI4-Lite register slave.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module pwm_deadband_autoshutdown
    import pwm_dbs_pkg::*;
#(
    parameter int PERIOD_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic comparator_1_in,
    input wire logic comparator_2_in,
    input wire logic fault_input_pin,
    output logic pwm_out_a,
    output logic pwm_oe_a,
    output logic pwm_out_b,
    output logic pwm_oe_b,
    output logic pwm_out_c,
    output logic pwm_oe_c,
    output logic pwm_out_d,
    output logic pwm_oe_d,
    output logic irq
);

    // ***************************************************************
    // Registers and internal state
    // ***************************************************************
    logic [7:0] pwm_delay_restart_config;
    logic [6:0] shutdown_control_reg;
    logic shutdown_active_flag;
    logic [2:0] ctrl;
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] duty;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [1:0] tcy_div;
    logic instruction_cycle;
    logic [PERIOD_W-1:0] pwm_cnt;
    logic period_start;
    logic raw;
    logic [2:0] src_meta;
    logic [2:0] src_sync;
    logic hold;
    logic [1:0] sched;
    logic [1:0] db;
    logic [DELAY_W-1:0] db_cnt [2];
    logic [3:0] pin_out;
    logic [3:0] pin_oe;

    logic pwm_en;
    logic half;
    logic auto_restart_enable;
    logic [DELAY_W-1:0] deadband_delay_count;
    logic [DELAY_W-1:0] dly_eff;
    logic [2:0] shutdown_source_select;
    logic [1:0] pair_ac_shutdown_state;
    logic [1:0] pair_bd_shutdown_state;
    logic cause;
    logic hw_set;
    logic auto_clear;
    logic sw_flag_wr;
    logic wr_go;
    logic rd_go;
    logic force_out;
    logic [3:0] active;
    logic [IRQ_W-1:0] events;
    logic [31:0] rd_word;
    logic rd_err;

    assign pwm_en = ctrl[CTRL_EN_BIT];
    assign half = ctrl[CTRL_HALF_BIT];
    assign auto_restart_enable = pwm_delay_restart_config[RESTART_BIT];
    assign deadband_delay_count = pwm_delay_restart_config[DELAY_W-1:0];
    assign shutdown_source_select = shutdown_control_reg[SEL_LSB +: 3];
    assign pair_ac_shutdown_state = shutdown_control_reg[AC_LSB +: 2];
    assign pair_bd_shutdown_state = shutdown_control_reg[BD_LSB +: 2];
    assign wr_go = aw_got && w_got && !bvalid;
    assign rd_go = arvalid && arready;

    // ***************************************************************
    // AXI4-Lite write channel
    // ***************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            wd <= '0;
            ws <= '0;
            bvalid <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_got <= 1'b1;
                aw_addr <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_got <= 1'b1;
                wd <= wdata;
                ws <= wstrb;
                wready <= 1'b0;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                aw_got <= 1'b0;
                w_got <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Writable registers; the shutdown flag has its own process below.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_delay_restart_config <= DELAY_CFG_RESET;
            shutdown_control_reg <= SHUTDOWN_RESET;
            ctrl <= '0;
            period <= PERIOD_RESET[PERIOD_W-1:0];
            duty <= '0;
            irq_mask <= '0;
            bresp <= RESP_OKAY;
        end else if (wr_go) begin
            bresp <= RESP_OKAY;
            case (aw_addr)
                OFF_DELAY_CFG: if (ws[0]) pwm_delay_restart_config <= wd[7:0];
                OFF_SHUTDOWN: if (ws[0]) shutdown_control_reg <= wd[6:0];
                OFF_CTRL: if (ws[0]) ctrl <= wd[2:0];
                OFF_PERIOD: begin
                    if (ws[0]) period[7:0] <= wd[7:0];
                    if (ws[1]) period[15:8] <= wd[15:8];
                end
                OFF_DUTY: begin
                    if (ws[0]) duty[7:0] <= wd[7:0];
                    if (ws[1]) duty[15:8] <= wd[15:8];
                end
                OFF_IRQ_MASK: if (ws[0]) irq_mask <= wd[IRQ_W-1:0];
                OFF_IRQ_STATUS, OFF_STATE: bresp <= RESP_OKAY;
                default: bresp <= RESP_SLVERR;
            endcase
        end
    end

    // ***************************************************************
    // AXI4-Lite read channel
    // ***************************************************************
    always_comb begin
        rd_word = '0;
        rd_err = 1'b0;
        case (araddr)
            OFF_DELAY_CFG: rd_word[7:0] = pwm_delay_restart_config;
            OFF_SHUTDOWN: rd_word[7:0] = {shutdown_active_flag, shutdown_control_reg};
            OFF_CTRL: rd_word[2:0] = ctrl;
            OFF_PERIOD: rd_word[PERIOD_W-1:0] = period;
            OFF_DUTY: rd_word[PERIOD_W-1:0] = duty;
            OFF_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_status;
            OFF_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
            OFF_STATE: rd_word[3:0] = {pin_oe != 4'h0, force_out, cause, shutdown_active_flag};
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (rd_go) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ***************************************************************
    // Instruction-cycle enable and PWM period counter
    // ***************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tcy_div <= '0;
            instruction_cycle <= 1'b0;
        end else begin
            tcy_div <= tcy_div + 2'h1;
            instruction_cycle <= (tcy_div == 2'(INSTR_CYCLE_CLKS - 1));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !pwm_en) begin
            pwm_cnt <= '0;
            period_start <= 1'b0;
            raw <= 1'b0;
        end else begin
            period_start <= 1'b0;
            if (instruction_cycle) begin
                raw <= pwm_cnt < duty;
                if (pwm_cnt >= period) begin
                    pwm_cnt <= '0;
                    period_start <= 1'b1;
                end else begin
                    pwm_cnt <= pwm_cnt + 1'b1;
                end
            end
        end
    end

    // ***************************************************************
    // Dead band
    // ***************************************************************
    // Single mode needs no complement, so the delay is bypassed there.
    assign dly_eff = half ? deadband_delay_count : '0;
    assign sched = {half && !raw, raw};

    for (genvar i = 0; i < 2; i++) begin : g_db
        always_ff @(posedge aclk) begin
            if (!aresetn || !sched[i]) begin
                db[i] <= 1'b0;
                db_cnt[i] <= '0;
            end else if (!db[i]) begin
                if (db_cnt[i] == dly_eff) begin
                    db[i] <= 1'b1;
                end else if (instruction_cycle) begin
                    db_cnt[i] <= db_cnt[i] + 1'b1;
                end
            end
        end
    end

    // ***************************************************************
    // Shutdown sources and flag
    // ***************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_meta <= '0;
            src_sync <= '0;
        end else begin
            src_meta <= {fault_input_pin, comparator_2_in, comparator_1_in};
            src_sync <= src_meta;
        end
    end

    // A level cause: it stays up until every selected source has dropped.
    assign cause = |(shutdown_source_select & src_sync);
    assign hw_set = pwm_en && cause;
    assign auto_clear = auto_restart_enable && !cause && shutdown_active_flag;
    assign sw_flag_wr = wr_go && aw_addr == OFF_SHUTDOWN && ws[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shutdown_active_flag <= 1'b0;
        end else if (hw_set) begin
            shutdown_active_flag <= 1'b1;
        end else if (auto_clear) begin
            shutdown_active_flag <= 1'b0;
        end else if (sw_flag_wr && !cause) begin
            // A selected cause blocks the write even while PWM is disabled.
            shutdown_active_flag <= wd[FLAG_BIT];
        end
    end

    // Hold keeps the pins forced until a period boundary sees the flag clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold <= 1'b0;
        end else if (shutdown_active_flag) begin
            hold <= 1'b1;
        end else if (period_start) begin
            hold <= 1'b0;
        end
    end

    assign force_out = shutdown_active_flag || hold || hw_set;

    // ***************************************************************
    // Output pins
    // ***************************************************************
    // Pins A and C carry the main phase, B and D the complement in half-bridge mode.
    assign active = half ? 4'hF : 4'h5;

    always_ff @(posedge aclk) begin
        if (!aresetn || !pwm_en) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            for (int p = 0; p < 4; p++) begin
                if (!active[p]) begin
                    pin_out[p] <= 1'b0;
                    pin_oe[p] <= 1'b0;
                end else if (force_out) begin
                    pin_out[p] <= ((p % 2 == 0) ? pair_ac_shutdown_state
                        : pair_bd_shutdown_state) == SHUT_HIGH;
                    pin_oe[p] <= !((p % 2 == 0) ? pair_ac_shutdown_state[1]
                        : pair_bd_shutdown_state[1]);
                end else begin
                    pin_out[p] <= db[p % 2];
                    pin_oe[p] <= 1'b1;
                end
            end
        end
    end

    assign {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a} = pin_out;
    assign {pwm_oe_d, pwm_oe_c, pwm_oe_b, pwm_oe_a} = pin_oe;

    // ***************************************************************
    // Interrupts
    // ***************************************************************
    assign events[IRQ_SHUTDOWN] = hw_set && !shutdown_active_flag;
    assign events[IRQ_RESTART] = auto_clear && !hw_set;
    assign events[IRQ_RESUMED] = hold && period_start && !shutdown_active_flag;

    // A new event in the reading cycle survives the read-clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            if (rd_go && araddr == OFF_IRQ_STATUS) begin
                irq_status <= events;
            end else begin
                irq_status <= irq_status | events;
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [DELAY_W-1:0] tcy_seen;
    always_ff @(posedge aclk) begin
        if (!aresetn || !sched[0] || db[0]) begin
            tcy_seen <= '0;
        end else if (instruction_cycle) begin
            tcy_seen <= tcy_seen + 1'b1;
        end
    end

    sequence s_flag_set;
        !shutdown_active_flag ##1 shutdown_active_flag;
    endsequence
    sequence s_forced_pair;
        pwm_oe_a == !pair_ac_shutdown_state[1] ##0 pwm_oe_b == (half && !pair_bd_shutdown_state[1]);
    endsequence

    property p_fall_undelayed;
        $fell(sched[0]) |=> !db[0];
    endproperty
    a_fall_undelayed: assert property (p_fall_undelayed) else $error("falling edge delayed");

    property p_delay_count;
        $rose(db[0]) |-> $past(tcy_seen) == dly_eff;
    endproperty
    a_delay_count: assert property (p_delay_count) else $error("dead band length wrong");

    property p_zero_delay;
        (dly_eff == 0 && $rose(sched[0])) |=> db[0];
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");

    property p_no_source;
        s_flag_set |-> $past(shutdown_source_select) != 0 || $past(sw_flag_wr);
    endproperty
    a_no_source: assert property (p_no_source) else $error("shutdown without source");

    property p_forced;
        (pwm_en && shutdown_active_flag) ##1 (pwm_en && shutdown_active_flag) |-> s_forced_pair;
    endproperty
    a_forced: assert property (p_forced) else $error("pins not in shutdown state");

    property p_write_blocked;
        (cause && sw_flag_wr && shutdown_active_flag) |=> shutdown_active_flag;
    endproperty
    a_write_blocked: assert property (p_write_blocked) else $error("flag cleared under cause");

    property p_auto_clear;
        (auto_clear && !hw_set) |=> !shutdown_active_flag;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("auto restart missed");

    property p_hold_period;
        (period_start && shutdown_active_flag) |=> hold throughout (!period_start [*1]);
    endproperty
    a_hold_period: assert property (p_hold_period) else $error("period not held");

    property p_resume_boundary;
        $fell(hold) |-> $past(period_start) && !$past(shutdown_active_flag);
    endproperty
    a_resume_boundary: assert property (p_resume_boundary) else $error("resumed mid-period");

endmodule

// ### pwm_dbs_pkg.sv
// Constants, register map and field layout of the PWM dead-band and auto-shutdown stage.
// Functional notes
// - In half-bridge mode only inactive-to-active edges are delayed, never falling ones.
// - Dead-band delay equals the seven-bit count, in instruction cycles of four clocks.
// - Auto-shutdown works on the active output pins in every PWM mode.
// - Three select bits pick any mix of two comparators and the fault pin.
// - With no source selected the block never enters auto-shutdown.
// - A shutdown event forces the pins to their shutdown states at once.
// - Two-bit fields set pair A/C and pair B/D high, low or tri-stated.
// - Hardware sets the shutdown flag on an event; outputs stay forced while set.
// - With restart enabled, hardware clears the flag once the cause has gone.
// - Flag set at a period start keeps outputs forced for that whole period.
// - After the flag clears, normal output resumes only at the next period start.
// - Software writes to the flag are ignored while a selected cause is active.
package pwm_dbs_pkg;

    // ***************************************************************
    // Register map (byte addresses) and bus answers
    // ***************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_DELAY_CFG = 8'h00;
    localparam logic [7:0] OFF_SHUTDOWN = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_PERIOD = 8'h0C;
    localparam logic [7:0] OFF_DUTY = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_STATE = 8'h1C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ***************************************************************
    // Field positions and reset values
    // ***************************************************************
    localparam int RESTART_BIT = 7;
    localparam int DELAY_W = 7;
    localparam int FLAG_BIT = 7;
    localparam int SEL_LSB = 4;
    localparam int AC_LSB = 2;
    localparam int BD_LSB = 0;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_HALF_BIT = 1;
    localparam int IRQ_W = 3;
    localparam int IRQ_SHUTDOWN = 0;
    localparam int IRQ_RESTART = 1;
    localparam int IRQ_RESUMED = 2;
    localparam logic [7:0] DELAY_CFG_RESET = 8'h00;
    localparam logic [6:0] SHUTDOWN_RESET = 7'h00;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

    // ***************************************************************
    // Shutdown pin states and timing
    // ***************************************************************
    localparam logic [1:0] SHUT_LOW = 2'h0;
    localparam logic [1:0] SHUT_HIGH = 2'h1;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int TOSC_PER_CYCLE = 4;
    localparam int INSTR_CYCLE_PS = TOSC_PER_CYCLE * CLK_PERIOD_PS;
    localparam int INSTR_CYCLE_CLKS = INSTR_CYCLE_PS / CLK_PERIOD_PS;

endpackage

// ### pwm_bridge_model.sv
// Behavioural half-bridge with two current comparators and a fault line.
`timescale 1ns/1ps
module pwm_bridge_model (
    input wire logic aclk,
    input wire logic high_on,
    input wire logic high_oe,
    input wire logic low_on,
    input wire logic low_oe,
    input wire logic [2:0] trip,
    output logic comparator_1_in,
    output logic comparator_2_in,
    output logic fault_input_pin,
    output logic shorted
);
    // Trips are held as levels until the bench drops them, as a real over-current would be.
    assign comparator_1_in = trip[0];
    assign comparator_2_in = trip[1];
    assign fault_input_pin = trip[2];
    // Both switches on together shorts the supply, so the bridge remembers it for good.
    initial shorted = 1'b0;
    always @(posedge aclk) begin
        if (high_oe && low_oe && high_on && low_on) begin
            shorted <= 1'b1;
        end
    end
endmodule

// ### pwm_deadband_autoshutdown_bench.sv
// Self-checking bench for the PWM dead-band and auto-shutdown stage.
`timescale 1ns/1ps
module pwm_deadband_autoshutdown_bench;
    import pwm_dbs_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = 8'h00;
    logic [ADDR_W-1:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [2:0] trip = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, shorted, cmp1, cmp2, flt;
    logic pa, pb, pc, pd, oa, ob, oc, od;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] pins;
    logic [6:0] cfg [3] = '{7'h14, 7'h21, 7'h49};
    logic [7:0] pexp [3] = '{8'hEE, 8'h88, 8'h33};
    logic [7:0] pmask [3] = '{8'hFF, 8'hFF, 8'hBB};
    int failures = 0;
    int checks_done = 0;
    int n;

    assign pins = {oa, pa, ob, pb, oc, pc, od, pd};
    always #4 aclk = ~aclk;

    pwm_deadband_autoshutdown dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .comparator_1_in(cmp1), .comparator_2_in(cmp2),
        .fault_input_pin(flt), .pwm_out_a(pa), .pwm_oe_a(oa), .pwm_out_b(pb), .pwm_oe_b(ob),
        .pwm_out_c(pc), .pwm_oe_c(oc), .pwm_out_d(pd), .pwm_oe_d(od), .irq(irq));
    pwm_bridge_model bridge_u (.aclk(aclk), .high_on(pa), .high_oe(oa), .low_on(pb),
        .low_oe(ob), .trip(trip), .comparator_1_in(cmp1), .comparator_2_in(cmp2),
        .fault_input_pin(flt), .shorted(shorted));

    // ***************************************************************
    // Bus cycles and comparisons
    // ***************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Ready signals are read before this edge's updates land, which is what the slave saw.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        k = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            k++;
        end while (bvalid !== 1'b1 && k < 50);
        if (bvalid !== 1'b1) failures++;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
        int k;
        k = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            k++;
        end while (rvalid !== 1'b1 && k < 50);
        if (rvalid !== 1'b1) failures++;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        chk("rdata", e, rdata & m);
    endtask

    // Counts clocks from a fall of pin A to the following rise of pin B.
    task automatic gap(output int g);
        g = 0;
        while (pa !== 1'b1 && g < 400) begin
            @(posedge aclk);
            g++;
        end
        g = 0;
        while (pa !== 1'b0 && g < 400) begin
            @(posedge aclk);
            g++;
        end
        g = 0;
        while (pb !== 1'b1 && g < 400) begin
            @(posedge aclk);
            g++;
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ***************************************************************
    // Tests
    // ***************************************************************
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFF_DELAY_CFG, 32'hFF, 32'h0, RESP_OKAY);
        rd(OFF_SHUTDOWN, 32'hFF, 32'h0, RESP_OKAY);
        rd(OFF_PERIOD, 32'hFFFF, 32'hFFFF, RESP_OKAY);
        rd(8'h20, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
        wr(8'h20, 32'h1, RESP_SLVERR);
        wr(OFF_PERIOD, 32'h13, RESP_OKAY);
        wr(OFF_DUTY, 32'hA, RESP_OKAY);
        wr(OFF_CTRL, 32'h3, RESP_OKAY);
        for (int d = 0; d < 6; d += 5) begin
            wr(OFF_DELAY_CFG, d, RESP_OKAY);
            gap(n);
            gap(n);
            chk("deadband", 32'h1, {31'h0, n >= 4 * d && n <= 4 * d + 2});
        end
        chk("shorted", 32'h0, {31'h0, shorted});
        wr(OFF_SHUTDOWN, 32'h0C, RESP_OKAY);
        trip <= 3'h7;
        repeat (6) @(posedge aclk);
        rd(OFF_SHUTDOWN, 32'h80, 32'h0, RESP_OKAY);
        trip <= 3'h0;
        wr(OFF_PERIOD, 32'h3E7, RESP_OKAY);
        wr(OFF_IRQ_MASK, 32'h1 << IRQ_SHUTDOWN, RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            wr(OFF_CTRL, 32'h0, RESP_OKAY);
            wr(OFF_DELAY_CFG, (i == 0) ? 32'h80 : 32'h0, RESP_OKAY);
            wr(OFF_SHUTDOWN, cfg[i], RESP_OKAY);
            // Restarting the counter puts the next period start well past the checks ahead of the 4100-clock wait below.
            wr(OFF_CTRL, (i == 1) ? 32'h1 : 32'h3, RESP_OKAY);
            trip <= 3'h1 << i;
            repeat (4) @(posedge aclk);
            chk("pins", pexp[i], pins & pmask[i]);
            // The interrupt line follows the status bit one clock later.
            @(posedge aclk);
            chk("irq", 32'h1, {31'h0, irq});
            rd(OFF_IRQ_STATUS, 32'h1, 32'h1, RESP_OKAY);
            wr(OFF_SHUTDOWN, cfg[i], RESP_OKAY);
            rd(OFF_SHUTDOWN, 32'hFF, {24'h0, 1'b1, cfg[i]}, RESP_OKAY);
            chk("irq", 32'h0, {31'h0, irq});
            trip <= 3'h0;
            repeat (8) @(posedge aclk);
            rd(OFF_SHUTDOWN, 32'h80, (i == 0) ? 32'h0 : 32'h80, RESP_OKAY);
            if (i != 0) wr(OFF_SHUTDOWN, cfg[i], RESP_OKAY);
            rd(OFF_STATE, 32'h5, 32'h4, RESP_OKAY);
            chk("pins", pexp[i], pins & pmask[i]);
            // One full period of 1000 instruction cycles must pass before output resumes.
            repeat (4100) @(posedge aclk);
            rd(OFF_STATE, 32'h4, 32'h0, RESP_OKAY);
            n = (i == 0) ? (1 << IRQ_RESTART) : 0;
            rd(OFF_IRQ_STATUS, 32'h6, n | (1 << IRQ_RESUMED), RESP_OKAY);
        end
        test_done();
    end

    initial begin
        repeat (30000) @(posedge aclk);
        failures++;
        test_done();
    end
endmodule
